//--- design/artc_cfg.svh
// register map, field positions, reset values and divider figures
`ifndef ARTC_CFG_SVH
`define ARTC_CFG_SVH

`define ARTC_ADDR_W       8
`define ARTC_ADDR_RATE    8'h01
`define ARTC_ADDR_TEST    8'h02
`define ARTC_RATE_RST     8'h06
`define ARTC_TEST_RST     8'h40

`define ARTC_HR_BIT       7
`define ARTC_READBACK_BIT 6
`define ARTC_OSC_EN_BIT   5
`define ARTC_RATE_MSB     2
`define ARTC_RATE_LSB     0
`define ARTC_RATE_RSVD    3'h7

`define ARTC_CHOP_BIT     5
`define ARTC_INT_TEST_BIT 4
`define ARTC_AMP_BIT      2
`define ARTC_TFREQ_MSB    1
`define ARTC_TFREQ_LSB    0

`define ARTC_MOD_DIV_HR   4'h4
`define ARTC_MOD_DIV_LP   4'h8
`define ARTC_RATE_BASE    12'h010
`define ARTC_CHOP_DIV     5'h10
`define ARTC_TEST_LOG2    21

`endif

//--- design/artc_pkg.sv
// shared types of the rate and test configuration block
package artc_pkg;
    typedef enum logic {ARTC_LOW_POWER, ARTC_HIGH_RES} artc_mode_e;
    typedef logic [1:0] artc_test_rate_t;
    localparam artc_test_rate_t ARTC_TEST_SLOW = 2'h0;
    localparam artc_test_rate_t ARTC_TEST_FAST = 2'h1;
    localparam artc_test_rate_t ARTC_TEST_DC   = 2'h3;
endpackage

//--- design/artc_tick_div.sv
// enable-driven divider giving one registered tick per div_i enables
`timescale 1ns/1ps
module artc_tick_div #(
    parameter int W = 12
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         en_i,
    input  wire logic [W-1:0] div_i,
    output logic              tick_o
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         wrap;

    // a shrinking divisor wraps at once instead of running past it
    assign wrap     = (cnt_reg >= div_i - W'(1));
    assign cnt_next = !en_i ? cnt_reg : (wrap ? '0 : cnt_reg + W'(1));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
            tick_o  <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_o  <= en_i && wrap;
        end
    end
endmodule

//--- design/artc_top.sv
// rate/mode and test-signal configuration registers with their decoded timing
// Notes on behaviour
// - bit 7 of rate register: 0 low power, 1 high resolution; resets 0
// - modulator tick is master clock over 4 (high res) or 8 (low power)
// - rate code n (0 to 6) gives conversions every 16 times 2^n modulator ticks; code 7 gives none
// - rate register at 0x01, resets to 0x06
// - bit 6: 0 daisy-chain output, 1 multiple readback
// - bit 5 with clock-select pin high drives oscillator onto clock pin
// - test register at 0x02, resets to 0x40
// - test bit 5 fixes chop tick at modulator over 16, else follows rate
// - test bit 4: 1 internal test signal, 0 external
// - test bit 2 doubles test amplitude
// - test rate 00 master/2^21, 01 master/2^20, 11 dc, 10 unused
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "artc_cfg.svh"
module artc_top import artc_pkg::*; #(
    parameter int TEST_LOG2 = `ARTC_TEST_LOG2
) (
    input  wire logic                    ref_clk_i,
    input  wire logic                    arst_n_i,
    input  wire logic [`ARTC_ADDR_W-1:0] addr_i,
    input  wire logic [7:0]              wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output logic      [7:0]              rdata_o,
    input  wire logic                    clock_source_pin_i,
    output logic                         clk_pin_o,
    output logic                         clk_pin_oe_o,
    output logic                         high_resolution_select_o,
    output logic                         multi_readback_o,
    output logic                         modulator_clock_tick_o,
    output logic                         conversion_tick_o,
    output logic                         terminal_chop_fixed_o,
    output logic                         chop_tick_o,
    output logic                         test_internal_o,
    output logic                         test_amplitude_select_o,
    output logic                         test_signal_o
);
    logic                 rst_meta_reg;
    logic                 rst_n;
    logic [7:0]           rate_cfg_reg;
    logic [7:0]           test_cfg_reg;
    logic [7:0]           rdata_next;
    logic                 wr_rate;
    logic                 wr_test;
    logic [2:0]           rate_code;
    artc_test_rate_t      test_rate;
    logic [3:0]           mod_div;
    logic [11:0]          rate_div;
    logic                 conv_en;
    logic                 chop_fixed_tick;
    logic [TEST_LOG2-1:0] free_cnt_reg;
    logic                 test_next;
    logic                 src_s1_reg;
    logic                 src_s2_reg;
    logic                 src_s3_reg;
    logic                 src_filt_reg;
    logic                 osc_oe_next;

    // reset release through two flops
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // register decode
    assign wr_rate = wr_i && (addr_i == `ARTC_ADDR_RATE);
    assign wr_test = wr_i && (addr_i == `ARTC_ADDR_TEST);
    assign rdata_next = !rd_i ? 8'h00 :
                        (addr_i == `ARTC_ADDR_RATE) ? rate_cfg_reg :
                        (addr_i == `ARTC_ADDR_TEST) ? test_cfg_reg : 8'h00;

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rate_cfg_reg <= `ARTC_RATE_RST;
            test_cfg_reg <= `ARTC_TEST_RST;
            rdata_o      <= 8'h00;
        end else begin
            if (wr_rate) begin
                rate_cfg_reg <= wdata_i;
            end
            if (wr_test) begin
                test_cfg_reg <= wdata_i;
            end
            rdata_o <= rdata_next;
        end
    end

    assign high_resolution_select_o = rate_cfg_reg[`ARTC_HR_BIT];
    assign multi_readback_o         = rate_cfg_reg[`ARTC_READBACK_BIT];
    assign terminal_chop_fixed_o    = test_cfg_reg[`ARTC_CHOP_BIT];
    assign test_internal_o          = test_cfg_reg[`ARTC_INT_TEST_BIT];
    assign test_amplitude_select_o  = test_cfg_reg[`ARTC_AMP_BIT];
    assign rate_code = rate_cfg_reg[`ARTC_RATE_MSB:`ARTC_RATE_LSB];
    assign test_rate = test_cfg_reg[`ARTC_TFREQ_MSB:`ARTC_TFREQ_LSB];

    assign mod_div = (artc_mode_e'(high_resolution_select_o) == ARTC_HIGH_RES) ?
                     `ARTC_MOD_DIV_HR : `ARTC_MOD_DIV_LP;
    assign rate_div = `ARTC_RATE_BASE << rate_code;
    assign conv_en  = modulator_clock_tick_o && (rate_code != `ARTC_RATE_RSVD);

    artc_tick_div #(.W(4)) u_mod_div (
        .clk_i   (ref_clk_i),
        .rst_n_i (rst_n),
        .en_i    (1'b1),
        .div_i   (mod_div),
        .tick_o  (modulator_clock_tick_o)
    );

    artc_tick_div #(.W(12)) u_rate_div (
        .clk_i   (ref_clk_i),
        .rst_n_i (rst_n),
        .en_i    (conv_en),
        .div_i   (rate_div),
        .tick_o  (conversion_tick_o)
    );

    artc_tick_div #(.W(5)) u_chop_div (
        .clk_i   (ref_clk_i),
        .rst_n_i (rst_n),
        .en_i    (modulator_clock_tick_o),
        .div_i   (`ARTC_CHOP_DIV),
        .tick_o  (chop_fixed_tick)
    );

    assign chop_tick_o = terminal_chop_fixed_o ? chop_fixed_tick : conversion_tick_o;

    // clock-select pin: three flops, change taken when stages two and three agree
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            src_s1_reg   <= 1'b0;
            src_s2_reg   <= 1'b0;
            src_s3_reg   <= 1'b0;
            src_filt_reg <= 1'b0;
        end else begin
            src_s1_reg <= clock_source_pin_i;
            src_s2_reg <= src_s1_reg;
            src_s3_reg <= src_s2_reg;
            if (src_s2_reg == src_s3_reg) begin
                src_filt_reg <= src_s3_reg;
            end
        end
    end

    assign osc_oe_next = rate_cfg_reg[`ARTC_OSC_EN_BIT] && src_filt_reg;
    // oscillator replica is the counter's lowest bit, master over 2
    assign clk_pin_o   = free_cnt_reg[0];

    always_comb begin
        case (test_rate)
            ARTC_TEST_SLOW: test_next = free_cnt_reg[TEST_LOG2-1];
            ARTC_TEST_FAST: test_next = free_cnt_reg[TEST_LOG2-2];
            ARTC_TEST_DC:   test_next = 1'b1;
            default:        test_next = 1'b0;
        endcase
        test_next = test_next && test_internal_o;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            free_cnt_reg  <= '0;
            test_signal_o <= 1'b0;
            clk_pin_oe_o  <= 1'b0;
        end else begin
            free_cnt_reg  <= free_cnt_reg + TEST_LOG2'(1);
            test_signal_o <= test_next;
            clk_pin_oe_o  <= osc_oe_next;
        end
    end

    // checking helpers: first cycle after reset, modulator ticks per conversion
    logic        first_reg;
    logic [12:0] mod_since_reg;
    logic        rate_dirty_reg;

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            first_reg      <= 1'b1;
            mod_since_reg  <= '0;
            rate_dirty_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
            if (conversion_tick_o) begin
                mod_since_reg  <= '0;
                rate_dirty_reg <= wr_rate;
            end else begin
                if (modulator_clock_tick_o) begin
                    mod_since_reg <= mod_since_reg + 13'h0001;
                end
                if (wr_rate) begin
                    rate_dirty_reg <= 1'b1;
                end
            end
        end
    end

    property p_mode_write;
        @(posedge ref_clk_i) disable iff (!rst_n)
        wr_rate |=> high_resolution_select_o == $past(wdata_i[`ARTC_HR_BIT]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode bit not taken");

    property p_mod_hr;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (modulator_clock_tick_o && high_resolution_select_o) |->
            ##1 !modulator_clock_tick_o [*3] ##1 (modulator_clock_tick_o || !high_resolution_select_o);
    endproperty
    a_mod_hr: assert property (p_mod_hr) else $error("modulator tick not every 4 in high res");

    property p_mod_lp;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (modulator_clock_tick_o && !high_resolution_select_o) |->
            ##1 (!modulator_clock_tick_o || high_resolution_select_o) [*7]
            ##1 (modulator_clock_tick_o || high_resolution_select_o);
    endproperty
    a_mod_lp: assert property (p_mod_lp) else $error("modulator tick not every 8 in low power");

    property p_rate;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (conversion_tick_o && !rate_dirty_reg) |-> mod_since_reg == {1'b0, rate_div};
    endproperty
    a_rate: assert property (p_rate) else $error("conversion spacing wrong");

    property p_reset_vals;
        @(posedge ref_clk_i) disable iff (!rst_n)
        first_reg |-> (rate_cfg_reg == `ARTC_RATE_RST) && (test_cfg_reg == `ARTC_TEST_RST);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");

    property p_readback_write;
        @(posedge ref_clk_i) disable iff (!rst_n)
        wr_rate |=> multi_readback_o == $past(wdata_i[`ARTC_READBACK_BIT]);
    endproperty
    a_readback_write: assert property (p_readback_write) else $error("readback bit not taken");

    property p_osc_off;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (!rate_cfg_reg[`ARTC_OSC_EN_BIT] || !src_filt_reg) |=> !clk_pin_oe_o;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("clock pin driven while disabled");

    property p_osc_on;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (rate_cfg_reg[`ARTC_OSC_EN_BIT] && src_filt_reg) |=> clk_pin_oe_o;
    endproperty
    a_osc_on: assert property (p_osc_on) else $error("clock pin not driven while enabled");

    property p_test_read;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (rd_i && addr_i == `ARTC_ADDR_TEST) |=> rdata_o == $past(test_cfg_reg) ##1 rdata_o == 8'h00 || rd_i;
    endproperty
    a_test_read: assert property (p_test_read) else $error("test register read wrong");

    property p_chop_fixed;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (chop_tick_o && terminal_chop_fixed_o && $stable(test_cfg_reg)) |=> !chop_tick_o [*8];
    endproperty
    a_chop_fixed: assert property (p_chop_fixed) else $error("fixed chop too fast");

    property p_internal_src;
        @(posedge ref_clk_i) disable iff (!rst_n)
        !test_internal_o |=> !test_signal_o;
    endproperty
    a_internal_src: assert property (p_internal_src) else $error("test signal with external source");

    property p_source_write;
        @(posedge ref_clk_i) disable iff (!rst_n)
        wr_test |=> test_internal_o == $past(wdata_i[`ARTC_INT_TEST_BIT]);
    endproperty
    a_source_write: assert property (p_source_write) else $error("test source bit not taken");

    property p_amp_write;
        @(posedge ref_clk_i) disable iff (!rst_n)
        wr_test |=> test_amplitude_select_o == $past(wdata_i[`ARTC_AMP_BIT]);
    endproperty
    a_amp_write: assert property (p_amp_write) else $error("amplitude bit not taken");

    property p_dc_test;
        @(posedge ref_clk_i) disable iff (!rst_n)
        (test_internal_o && test_rate == ARTC_TEST_DC) |=> test_signal_o;
    endproperty
    a_dc_test: assert property (p_dc_test) else $error("dc test signal not high");

    property p_square;
        @(posedge ref_clk_i) disable iff (!rst_n)
        // output edge at k was built from the settings of cycle k-1, so those must match k-2
        ($past(test_internal_o && test_rate == ARTC_TEST_FAST)
            && ($past(test_cfg_reg) == $past(test_cfg_reg, 2)) && $changed(test_signal_o))
            |-> free_cnt_reg[TEST_LOG2-3:0] == (TEST_LOG2-2)'(1);
    endproperty
    a_square: assert property (p_square) else $error("test edge off the counter boundary");
endmodule

//--- testbench/artc_top_tb.sv
// self-checking bench for the rate/mode and test-signal configuration block
`timescale 1ns/1ps
`include "artc_cfg.svh"
module artc_top_tb import artc_pkg::*; ;
    localparam int LOG2 = 6;
    localparam int LIM  = 20000;
    logic       ref_clk_i = 1'b0;
    logic       arst_n_i  = 1'b0;
    logic [7:0] addr_i    = 8'h00;
    logic [7:0] wdata_i   = 8'h00;
    logic       wr_i      = 1'b0;
    logic       rd_i      = 1'b0;
    logic       pin_i     = 1'b0;
    logic [7:0] rdata_o;
    logic       clk_pin_o, clk_pin_oe_o, hr_o, rb_o, mod_o, conv_o, chopf_o, chop_o, int_o, amp_o, tsig_o;
    int         fails      = 0;
    int         n_compared = 0;

    artc_top #(.TEST_LOG2(LOG2)) i_dut (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .clock_source_pin_i(pin_i),
        .clk_pin_o(clk_pin_o), .clk_pin_oe_o(clk_pin_oe_o), .high_resolution_select_o(hr_o),
        .multi_readback_o(rb_o), .modulator_clock_tick_o(mod_o), .conversion_tick_o(conv_o),
        .terminal_chop_fixed_o(chopf_o), .chop_tick_o(chop_o), .test_internal_o(int_o),
        .test_amplitude_select_o(amp_o), .test_signal_o(tsig_o)
    );

    always #50 ref_clk_i = ~ref_clk_i;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
        wr_i    <= 1'b0;
        @(negedge ref_clk_i);
    endtask

    // data one cycle after the strobe, zero the cycle after that
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i   <= 1'b0;
        @(negedge ref_clk_i);
        chk(rdata_o, exp);
        @(negedge ref_clk_i);
        chk(rdata_o, 8'h00);
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return mod_o;
            1: return conv_o;
            2: return chop_o;
            default: return tsig_o;
        endcase
    endfunction

    // rising to rising distance and high time of a selected output
    task automatic per(input int s, input int exp_p, input int exp_h);
        int n;
        int p;
        int h;
        n = 0;
        p = 0;
        h = 0;
        while (pick(s) !== 1'b0 && n < LIM) begin
            @(negedge ref_clk_i);
            n++;
        end
        while (pick(s) !== 1'b1 && n < 2 * LIM) begin
            @(negedge ref_clk_i);
            n++;
        end
        while (pick(s) === 1'b1 && p < LIM) begin
            @(negedge ref_clk_i);
            p++;
            h++;
        end
        while (pick(s) !== 1'b1 && p < LIM) begin
            @(negedge ref_clk_i);
            p++;
        end
        chk(p[15:0], exp_p[15:0]);
        chk(h[15:0], exp_h[15:0]);
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #(100 * 50000);
        fails++;
        summarize();
    end

    initial begin
        int c;
        repeat (20) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        repeat (4) @(negedge ref_clk_i);
        chk({hr_o, rb_o, chopf_o, int_o, amp_o, clk_pin_oe_o, tsig_o}, 16'h0000);
        rd(`ARTC_ADDR_RATE, `ARTC_RATE_RST);
        rd(`ARTC_ADDR_TEST, `ARTC_TEST_RST);
        per(0, 8, 1);
        per(1, 8 * 1024, 1);
        wr(8'h03, 8'hff);
        rd(8'h03, 8'h00);
        rd(`ARTC_ADDR_RATE, `ARTC_RATE_RST);
        wr(`ARTC_ADDR_RATE, 8'h80);
        chk(hr_o, 16'h0001);
        per(0, 4, 1);
        per(1, 4 * 16, 1);
        per(2, 4 * 16, 1);
        wr(`ARTC_ADDR_RATE, 8'h81);
        per(1, 4 * 32, 1);
        wr(`ARTC_ADDR_TEST, 8'h20);
        chk(chopf_o, 16'h0001);
        per(2, 4 * 16, 1);
        wr(`ARTC_ADDR_RATE, 8'h01);
        per(0, 8, 1);
        per(1, 8 * 32, 1);
        // slowest legal code, reserved code never written: no conversion soon after one
        wr(`ARTC_ADDR_RATE, 8'h86);
        per(1, 4 * 1024, 1);
        c = 0;
        repeat (600) begin
            @(negedge ref_clk_i);
            if (conv_o === 1'b1) c++;
        end
        chk(c[15:0], 16'h0000);
        wr(`ARTC_ADDR_RATE, 8'h40);
        chk({hr_o, rb_o}, 16'h0001);
        rd(`ARTC_ADDR_RATE, 8'h40);
        wr(`ARTC_ADDR_RATE, 8'h26);
        @(posedge ref_clk_i);
        pin_i <= 1'b1;
        repeat (8) @(negedge ref_clk_i);
        chk(clk_pin_oe_o, 16'h0001);
        c = clk_pin_o;
        @(negedge ref_clk_i);
        chk(clk_pin_o, {15'h0000, ~c[0]});
        @(posedge ref_clk_i);
        pin_i <= 1'b0;
        repeat (8) @(negedge ref_clk_i);
        chk(clk_pin_oe_o, 16'h0000);
        wr(`ARTC_ADDR_RATE, 8'h06);
        @(posedge ref_clk_i);
        pin_i <= 1'b1;
        repeat (8) @(negedge ref_clk_i);
        chk(clk_pin_oe_o, 16'h0000);
        wr(`ARTC_ADDR_TEST, 8'h10);
        chk({int_o, amp_o}, 16'h0002);
        per(3, 1 << LOG2, 1 << (LOG2 - 1));
        wr(`ARTC_ADDR_TEST, 8'h11);
        per(3, 1 << (LOG2 - 1), 1 << (LOG2 - 2));
        wr(`ARTC_ADDR_TEST, {6'h05, ARTC_TEST_DC});
        repeat (4) @(negedge ref_clk_i);
        chk({int_o, amp_o, tsig_o}, 16'h0007);
        wr(`ARTC_ADDR_TEST, 8'h12);
        repeat (4) @(negedge ref_clk_i);
        chk(tsig_o, 16'h0000);
        wr(`ARTC_ADDR_TEST, {6'h00, ARTC_TEST_DC});
        repeat (4) @(negedge ref_clk_i);
        chk({int_o, tsig_o}, 16'h0000);
        rd(`ARTC_ADDR_TEST, 8'h03);
        summarize();
    end
endmodule
